// file: sim/ctpp_pin_model.sv
// External carrier source driving one of the two demodulator input pins
`timescale 1ns/1ps
module ctpp_pin_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic pin_sel,
  input wire logic [7:0] width,
  output logic src_port2,
  output logic src_port3
);
  logic [7:0] left_q;
  // Pulse length counter; a new request restarts the burst
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_q <= 8'h00;
    end else if (go) begin
      left_q <= width;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Idle pins rest low, as with a pull-down on the carrier line
  assign src_port2 = (left_q != 8'h00) && !pin_sel;
  assign src_port3 = (left_q != 8'h00) && pin_sel;
endmodule

// file: sim/test_carrier_timer_capture_pingpong.sv
// Self-checking bench for the carrier timer pair
`timescale 1ns/1ps
`include "ctpp_defines.svh"
module test_carrier_timer_capture_pingpong;
  logic clk_sys, rst, psel, penable, pwrite, pv, go, pin_sel, err;
  logic pready, pslverr, src_port2, src_port3, shared_pin, n_out, w_out, n_irq, w_irq, ext_irq;
  logic [7:0] paddr, width, rd;
  logic [31:0] pwdata, prdata;
  logic [1:0] last_src;
  int num_errors, checks_done, n_cnt, w_cnt, x2_cnt, alt_bad;

  ctpp_top i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port2_bit0_input(src_port2), .port3_bit1_input(src_port3),
    .port3_bit6_port_value(pv), .port3_bit6_output(shared_pin), .narrow_timer_output(n_out),
    .wide_timer_output(w_out), .narrow_irq(n_irq), .wide_irq(w_irq),
    .external_interrupt_request_two(ext_irq));
  ctpp_pin_model i_pins (.clk_sys(clk_sys), .rst(rst), .go(go), .pin_sel(pin_sel),
    .width(width), .src_port2(src_port2), .src_port3(src_port3));

  // Clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Interrupt pulse counters; alternation faults show as a repeated source
  always @(posedge clk_sys) begin
    if (n_irq === 1'b1) begin
      n_cnt++;
      if (last_src == 2'h1) alt_bad++;
      last_src = 2'h1;
    end
    if (w_irq === 1'b1) begin
      w_cnt++;
      if (last_src == 2'h2) alt_bad++;
      last_src = 2'h2;
    end
    if (ext_irq === 1'b1) x2_cnt++;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, exp, rd);
  endtask

  // Ask the carrier source for a high burst, then let the line settle low
  task automatic pulse(input logic sel, input logic [7:0] w);
    @(posedge clk_sys);
    go <= 1'b1;
    pin_sel <= sel;
    width <= w;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (int'(w) + 20) @(posedge clk_sys);
  endtask

  task automatic t_regs;
    rchk("common reset", `CTPP_IDX_COMMON, 8'h00);
    rchk("ctl3 reset", `CTPP_IDX_CTL3, 8'h1f);
    rchk("narrow cap reset", `CTPP_IDX_NCAP_HI, 8'h00);
    wreg(`CTPP_IDX_CTL3, 8'hff);
    rchk("ctl3 all ones", `CTPP_IDX_CTL3, 8'hff);
    wreg(`CTPP_IDX_CTL3, 8'h00);
    rchk("ctl3 low bits fixed", `CTPP_IDX_CTL3, 8'h1f);
    apb(1'b0, 4'hc, 8'h00);
    chk("unmapped error", 8'h01, {7'h0, err});
    chk("unmapped data", 8'h00, rd);
  endtask

  // Transmit output levels before any timer runs: {port value, narrow, wide, pin}
  task automatic t_tx_levels;
    logic [7:0] cm [6] = '{8'h0c, 8'h4c, 8'h0a, 8'h4a, 8'h48, 8'h01};
    logic [3:0] ex [6] = '{4'h2, 4'h3, 4'hd, 4'h5, 4'h8, 4'h2};
    for (int i = 0; i < 6; i++) begin
      pv <= ex[i][3];
      wreg(`CTPP_IDX_COMMON, cm[i]);
      repeat (3) @(posedge clk_sys);
      chk("narrow level", {7'h0, ex[i][2]}, {7'h0, n_out});
      chk("wide level", {7'h0, ex[i][1]}, {7'h0, w_out});
      chk("shared pin", {7'h0, ex[i][0]}, {7'h0, shared_pin});
    end
  endtask

  task automatic t_demod;
    int c0;
    c0 = x2_cnt;
    wreg(`CTPP_IDX_COMMON, 8'ha3);
    // Both timers must run for the level counter and the wide capture
    wreg(`CTPP_IDX_NCTL, 8'h80);
    wreg(`CTPP_IDX_WCTL, 8'h80);
    pulse(1'b0, 8'd20);
    pulse(1'b0, 8'd20);
    apb(1'b0, `CTPP_IDX_NCAP_HI, 8'h00);
    chk("high time near 20", 8'h01, {7'h0, rd >= 8'd18 && rd <= 8'd22});
    apb(1'b0, `CTPP_IDX_NCAP_LO, 8'h00);
    chk("low time near 21", 8'h01, {7'h0, rd >= 8'd18 && rd <= 8'd24});
    chk("no ext irq from port2", 8'h01, {7'h0, x2_cnt == c0});
    rchk("edge flags set", `CTPP_IDX_COMMON, 8'ha3);
    wreg(`CTPP_IDX_COMMON, 8'ha2);
    rchk("rising flag cleared", `CTPP_IDX_COMMON, 8'ha1);
  endtask

  // Filter widths 4 and 8: a narrower burst is dropped, a wider one is seen
  task automatic t_filter;
    logic [7:0] code [2] = '{8'h04, 8'h08};
    logic [7:0] shrt [2] = '{8'd2, 8'd6};
    logic [7:0] lng [2] = '{8'd6, 8'd10};
    for (int i = 0; i < 2; i++) begin
      wreg(`CTPP_IDX_COMMON, 8'ha3 | code[i]);
      pulse(1'b0, shrt[i]);
      apb(1'b0, `CTPP_IDX_COMMON, 8'h00);
      chk("short burst flags", 8'h00, rd & 8'h03);
      pulse(1'b0, lng[i]);
      apb(1'b0, `CTPP_IDX_COMMON, 8'h00);
      chk("long burst flags", 8'h03, rd & 8'h03);
    end
  endtask

  task automatic t_external_interrupt_request_two;
    int c0;
    c0 = x2_cnt;
    wreg(`CTPP_IDX_COMMON, 8'he3);
    pulse(1'b1, 8'd20);
    chk("ext irq from port3", 8'h01, {7'h0, x2_cnt > c0});
    rchk("port3 edge flags", `CTPP_IDX_COMMON, 8'he3);
  endtask

  task automatic t_wrap;
    int c0;
    c0 = w_cnt;
    // Stop the wide timer so the enable below is a fresh start with reload
    wreg(`CTPP_IDX_WCTL, 8'h00);
    wreg(`CTPP_IDX_WRLD_HI, 8'h00);
    wreg(`CTPP_IDX_WRLD_LO, 8'h04);
    wreg(`CTPP_IDX_WCTL, 8'h82);
    repeat (40) @(posedge clk_sys);
    chk("wide timeout irq", 8'h01, {7'h0, w_cnt > c0});
    apb(1'b0, `CTPP_IDX_WCTL, 8'h00);
    chk("wide timeout flag", 8'h20, rd & 8'h20);
    wreg(`CTPP_IDX_WCTL, 8'h20);
    rchk("wide flag cleared", `CTPP_IDX_WCTL, 8'h00);
  endtask

  // Hold mode: edges ignored, narrow timeout captures, 0 then 1 arms one edge
  task automatic t_hold;
    int c0;
    // Two hold writes in a row leave the single capture disarmed
    wreg(`CTPP_IDX_WCTL, 8'hc4);
    wreg(`CTPP_IDX_WCTL, 8'hc4);
    // First burst only restarts the narrow level counter
    pulse(1'b1, 8'd20);
    c0 = w_cnt;
    pulse(1'b1, 8'd20);
    chk("hold ignores edges", 8'h00, 8'(w_cnt - c0));
    repeat (300) @(posedge clk_sys);
    chk("hold timeout capture", 8'h01, 8'(w_cnt - c0));
    c0 = w_cnt;
    wreg(`CTPP_IDX_WCTL, 8'h84);
    wreg(`CTPP_IDX_WCTL, 8'hc4);
    pulse(1'b1, 8'd20);
    chk("armed single capture", 8'h01, 8'(w_cnt - c0));
  endtask

  task automatic t_pingpong;
    int n0, w0, a0, s1;
    // timers stopped and flags cleared first
    wreg(`CTPP_IDX_NCTL, 8'h20);
    wreg(`CTPP_IDX_WCTL, 8'h20);
    wreg(`CTPP_IDX_NRLD_LO, 8'h05);
    wreg(`CTPP_IDX_NRLD_HI, 8'h05);
    wreg(`CTPP_IDX_WRLD_LO, 8'h08);
    wreg(`CTPP_IDX_COMMON, 8'h06);
    wreg(`CTPP_IDX_WCTL, 8'h42);
    n0 = n_cnt;
    w0 = w_cnt;
    a0 = alt_bad;
    wreg(`CTPP_IDX_NCTL, 8'hc2);
    repeat (2) @(posedge clk_sys);
    chk("narrow start level", 8'h01, {7'h0, n_out});
    repeat (100) @(posedge clk_sys);
    chk("narrow tc irqs", 8'h01, {7'h0, n_cnt - n0 >= 2});
    chk("wide tc irqs", 8'h01, {7'h0, w_cnt - w0 >= 2});
    chk("timers alternate", 8'h01, {7'h0, alt_bad == a0});
    wreg(`CTPP_IDX_COMMON, 8'h02);
    repeat (20) @(posedge clk_sys);
    s1 = n_cnt + w_cnt;
    repeat (100) @(posedge clk_sys);
    chk("ping-pong ended", 8'h01, {7'h0, n_cnt + w_cnt == s1});
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pv = 1'b0;
    go = 1'b0;
    pin_sel = 1'b0;
    width = 8'h00;
    last_src = 2'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_tx_levels();
    t_demod();
    t_filter();
    t_external_interrupt_request_two();
    t_wrap();
    t_hold();
    t_pingpong();
    complete_run();
  end

  // Watchdog well beyond the roughly 1100 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
endmodule

// file: src/ctpp_defines.svh
// Register indices, field positions and timing counts of the carrier timer pair
`ifndef CTPP_DEFINES_SVH
`define CTPP_DEFINES_SVH
`define CTPP_IDX_NCTL 4'h0
`define CTPP_IDX_COMMON 4'h1
`define CTPP_IDX_WCTL 4'h2
`define CTPP_IDX_CTL3 4'h3
`define CTPP_IDX_NRLD_LO 4'h4
`define CTPP_IDX_NRLD_HI 4'h5
`define CTPP_IDX_WRLD_LO 4'h6
`define CTPP_IDX_WRLD_HI 4'h7
`define CTPP_IDX_WCAP_LO 4'h8
`define CTPP_IDX_WCAP_HI 4'h9
`define CTPP_IDX_NCAP_LO 4'ha
`define CTPP_IDX_NCAP_HI 4'hb
`define CTPP_CM_MODE 7
`define CTPP_CM_PINSEL 6
`define CTPP_CM_EDGE_HI 5
`define CTPP_CM_EDGE_LO 4
`define CTPP_CM_SUB_HI 3
`define CTPP_CM_SUB_LO 2
`define CTPP_CM_INIT_N 1
`define CTPP_CM_INIT_W 0
`define CTPP_CT_EN 7
`define CTPP_CT_SP 6
`define CTPP_CT_TOF 5
`define CTPP_CT_CIE 2
`define CTPP_CT_TIE 1
`define CTPP_CTL3_RSVD 5'h1f
`define CTPP_FILT_SHORT 4'h4
`define CTPP_FILT_LONG 4'h8
`define CTPP_RST_BYTE 8'h00
`define CTPP_WRAP 16'hffff
`endif

// file: src/ctpp_pkg.sv
// Types shared by the carrier timer pair
package ctpp_pkg;
  typedef enum logic [1:0] {
    CTPP_SUB_NORMAL = 2'h0,
    CTPP_SUB_PINGPONG = 2'h1,
    CTPP_SUB_FORCE_LO = 2'h2,
    CTPP_SUB_FORCE_HI = 2'h3
  } ctpp_submode_type;
  typedef enum logic [1:0] {
    CTPP_EDGE_FALL = 2'h0,
    CTPP_EDGE_RISE = 2'h1,
    CTPP_EDGE_BOTH = 2'h2,
    CTPP_EDGE_BOTH2 = 2'h3
  } ctpp_edge_type;
endpackage

// file: src/ctpp_top.sv
// Carrier timer pair: narrow and wide timers, demodulator capture, APB registers
// Summary of operation
// - Narrow high capture takes the count while the filtered input was high.
// - Narrow low capture takes the count while the filtered input was low.
// - Wide capture splits the wide count: high byte and low byte registers.
// - Glitch filter drops pulses shorter than none, 4 or 8 clocks; 11 reserved.
// - Edge detector pulses on rising, falling or both edges per edge select.
// - Transmit: common bit 1 gives narrow output level before start.
// - Transmit: common bit 0 gives wide output initial level.
// - Mode bit 0 means transmit, otherwise demodulation.
// - Transmit: pin select chooses port value or combined timer output.
// - Demodulation: pin select chooses port2 bit0 or port3 bit1 input.
// - Captures from port3 bit1 also raise external interrupt request two.
// - Hold mode: wide timer ignores edges, captures on narrow timeout, no reload.
// - Writing hold 0 then 1 arms one capture and reload on next edge.
// - Wide timer wraps from zero to all ones, sets flag, may interrupt.
// - Ping-pong starts when software enables either timer.
// - Narrow start loads high or low reload per initial output level.
// - Terminal counts hand over between narrow and wide timers alternately.
// - Each terminal count interrupts when that timer enables it.
// - Writing submode 00 ends ping-pong.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ctpp_defines.svh"
module ctpp_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port2_bit0_input,
  input wire logic port3_bit1_input,
  input wire logic port3_bit6_port_value,
  output logic port3_bit6_output,
  output logic narrow_timer_output,
  output logic wide_timer_output,
  output logic narrow_irq,
  output logic wide_irq,
  output logic external_interrupt_request_two
);
  import ctpp_pkg::*;

  logic [7:0] nctl_q, common_q, wctl_q, ctl3_q;
  logic [7:0] nrld_lo_q, nrld_hi_q, wrld_lo_q, wrld_hi_q;
  logic [7:0] wcap_lo_q, wcap_hi_q, ncap_lo_q, ncap_hi_q;
  logic [7:0] n_cnt_q;
  logic [15:0] w_cnt_q;
  logic n_out_q, w_out_q, n_en_prev_q, w_en_prev_q;
  logic filt_q, filt_prev_q, rise_flag_q, fall_flag_q;
  logic [3:0] filt_cnt_q, filt_w;
  logic hold_cleared_q, armed_q;
  logic [31:0] prdata_q;
  logic wr, rd_setup, mapped, tx_mode, pingpong, sel_in;
  logic rise, fall, sel_edge, n_start, w_start, n_run, w_run;
  logic n_tc, w_tc, n_tmo, w_wrap, w_cap_edge, w_cap_tmo, w_cap;
  logic [3:0] idx;
  logic [7:0] wd;
  ctpp_submode_type submode;
  ctpp_edge_type edge_sel;

  // Index decode; byte address is four times the index, upper bits must be zero
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == '0) && (a[5:2] <= `CTPP_IDX_NCAP_HI);
  endfunction

  // Bus decode; zero wait states, writes commit at the access edge
  assign idx = paddr[5:2];
  assign wd = pwdata[7:0];
  assign mapped = is_mapped(paddr);
  assign wr = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  // Mode and option decode from the common register
  // transmit when mode is 0
  assign tx_mode = ~common_q[`CTPP_CM_MODE];
  assign submode = ctpp_submode_type'(common_q[`CTPP_CM_SUB_HI:`CTPP_CM_SUB_LO]);
  assign edge_sel = ctpp_edge_type'(common_q[`CTPP_CM_EDGE_HI:`CTPP_CM_EDGE_LO]);
  assign pingpong = tx_mode & (submode == CTPP_SUB_PINGPONG);
  assign sel_in = common_q[`CTPP_CM_PINSEL] ? port3_bit1_input : port2_bit0_input;

  // Timer run and start strobes; a start is the first cycle after enable rises
  // either enable bit starts its timer
  assign n_start = nctl_q[`CTPP_CT_EN] & ~n_en_prev_q;
  assign w_start = wctl_q[`CTPP_CT_EN] & ~w_en_prev_q;
  assign n_run = nctl_q[`CTPP_CT_EN] & n_en_prev_q;
  assign w_run = wctl_q[`CTPP_CT_EN] & w_en_prev_q;
  assign n_tc = tx_mode & n_run & (n_cnt_q == 8'h00);
  assign w_tc = tx_mode & w_run & (w_cnt_q == 16'h0000);
  assign n_tmo = ~tx_mode & n_run & (n_cnt_q == 8'hff);
  assign w_wrap = ~tx_mode & w_run & (w_cnt_q == 16'h0000);

  // edge pulses from the filtered level
  assign rise = ~tx_mode & filt_q & ~filt_prev_q;
  assign fall = ~tx_mode & ~filt_q & filt_prev_q;
  always_comb begin
    unique case (edge_sel)
      CTPP_EDGE_FALL: sel_edge = fall;
      CTPP_EDGE_RISE: sel_edge = rise;
      default: sel_edge = rise | fall;
    endcase
  end

  // hold mode ignores edges and captures on narrow timeout
  assign w_cap_tmo = w_run & wctl_q[`CTPP_CT_SP] & n_tmo;
  // edge capture in normal mode, or once when armed in hold mode
  assign w_cap_edge = w_run & sel_edge & (~wctl_q[`CTPP_CT_SP] | armed_q);
  assign w_cap = w_cap_edge | w_cap_tmo;

  // glitch filter width; reserved code behaves as no filter
  always_comb begin
    unique case (common_q[`CTPP_CM_SUB_HI:`CTPP_CM_SUB_LO])
      2'h1: filt_w = `CTPP_FILT_SHORT;
      2'h2: filt_w = `CTPP_FILT_LONG;
      default: filt_w = 4'h0;
    endcase
  end

  // Filter: level moves only after the input differs for the full width
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      filt_q <= 1'b0;
      filt_cnt_q <= 4'h0;
      filt_prev_q <= 1'b0;
    end else begin
      filt_prev_q <= filt_q;
      // drop pulses narrower than the width
      if (sel_in == filt_q) begin
        filt_cnt_q <= 4'h0;
      end else if (filt_w == 4'h0 || filt_cnt_q == filt_w - 4'h1) begin
        filt_q <= sel_in;
        filt_cnt_q <= 4'h0;
      end else begin
        filt_cnt_q <= filt_cnt_q + 4'h1;
      end
    end
  end

  // Control registers; hardware sets win over software clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nctl_q <= `CTPP_RST_BYTE;
      wctl_q <= `CTPP_RST_BYTE;
      common_q <= `CTPP_RST_BYTE;
      ctl3_q <= `CTPP_RST_BYTE;
    end else begin
      if (wr && idx == `CTPP_IDX_NCTL) nctl_q <= {wd[7:6], nctl_q[5] & ~wd[5], wd[4:0]};
      if (wr && idx == `CTPP_IDX_WCTL) wctl_q <= {wd[7:6], wctl_q[5] & ~wd[5], wd[4:0]};
      if (wr && idx == `CTPP_IDX_COMMON) begin
        // Init level bits only take writes in transmit; in demod they clear flags
        common_q[7:2] <= wd[7:2];
        if (tx_mode) common_q[1:0] <= wd[1:0];
      end
      // only the upper bits of control three store
      if (wr && idx == `CTPP_IDX_CTL3) ctl3_q <= {wd[7:5], 5'h00};
      // terminal count hands the run over in ping-pong
      if (n_tc && (pingpong || nctl_q[`CTPP_CT_SP])) nctl_q[`CTPP_CT_EN] <= 1'b0;
      if (w_tc && pingpong) nctl_q[`CTPP_CT_EN] <= 1'b1;
      if (w_tc && (pingpong || wctl_q[`CTPP_CT_SP])) wctl_q[`CTPP_CT_EN] <= 1'b0;
      if (n_tc && pingpong) wctl_q[`CTPP_CT_EN] <= 1'b1;
      if (n_tc || n_tmo) nctl_q[`CTPP_CT_TOF] <= 1'b1;
      if (w_tc || w_wrap) wctl_q[`CTPP_CT_TOF] <= 1'b1;
    end
  end

  // sticky edge flags; set wins over a write-one clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else begin
      if (rise) begin
        rise_flag_q <= 1'b1;
      end else if (wr && idx == `CTPP_IDX_COMMON && !tx_mode && wd[`CTPP_CM_INIT_N]) begin
        rise_flag_q <= 1'b0;
      end
      if (fall) begin
        fall_flag_q <= 1'b1;
      end else if (wr && idx == `CTPP_IDX_COMMON && !tx_mode && wd[`CTPP_CM_INIT_W]) begin
        fall_flag_q <= 1'b0;
      end
    end
  end

  // arm a single capture after hold is written 0 then 1
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_cleared_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (wr && idx == `CTPP_IDX_WCTL) begin
        hold_cleared_q <= ~wd[`CTPP_CT_SP];
        armed_q <= wd[`CTPP_CT_SP] & hold_cleared_q;
      end else if (w_cap_edge) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Reload registers, written by software at the access edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nrld_lo_q <= `CTPP_RST_BYTE;
      nrld_hi_q <= `CTPP_RST_BYTE;
      wrld_lo_q <= `CTPP_RST_BYTE;
      wrld_hi_q <= `CTPP_RST_BYTE;
    end else if (wr) begin
      if (idx == `CTPP_IDX_NRLD_LO) nrld_lo_q <= wd;
      if (idx == `CTPP_IDX_NRLD_HI) nrld_hi_q <= wd;
      if (idx == `CTPP_IDX_WRLD_LO) wrld_lo_q <= wd;
      if (idx == `CTPP_IDX_WRLD_HI) wrld_hi_q <= wd;
    end
  end

  // Narrow timer: transmit waveform or demodulator level counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      n_cnt_q <= 8'h00;
      n_out_q <= 1'b0;
      n_en_prev_q <= 1'b0;
      ncap_lo_q <= `CTPP_RST_BYTE;
      ncap_hi_q <= `CTPP_RST_BYTE;
    end else begin
      n_en_prev_q <= nctl_q[`CTPP_CT_EN];
      if (wr && idx == `CTPP_IDX_NCAP_LO) ncap_lo_q <= wd;
      if (wr && idx == `CTPP_IDX_NCAP_HI) ncap_hi_q <= wd;
      if (tx_mode) begin
        if (!nctl_q[`CTPP_CT_EN]) begin
          // idle level follows the programmed start level
          n_out_q <= common_q[`CTPP_CM_INIT_N];
        end else if (n_start) begin
          // reload byte chosen by the start level
          n_out_q <= common_q[`CTPP_CM_INIT_N];
          n_cnt_q <= common_q[`CTPP_CM_INIT_N] ? nrld_hi_q : nrld_lo_q;
        end else if (n_tc) begin
          n_out_q <= ~n_out_q;
          n_cnt_q <= n_out_q ? nrld_lo_q : nrld_hi_q;
        end else begin
          n_cnt_q <= n_cnt_q - 8'h01;
        end
      end else if (filt_q != filt_prev_q) begin
        if (filt_prev_q) ncap_hi_q <= n_cnt_q;
        else ncap_lo_q <= n_cnt_q;
        n_cnt_q <= 8'h00;
      end else if (n_run) begin
        n_cnt_q <= n_cnt_q + 8'h01;
      end
    end
  end

  // Wide timer: transmit waveform or demodulator down counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      w_cnt_q <= 16'h0000;
      w_out_q <= 1'b0;
      w_en_prev_q <= 1'b0;
      wcap_lo_q <= `CTPP_RST_BYTE;
      wcap_hi_q <= `CTPP_RST_BYTE;
    end else begin
      w_en_prev_q <= wctl_q[`CTPP_CT_EN];
      if (wr && idx == `CTPP_IDX_WCAP_LO) wcap_lo_q <= wd;
      if (wr && idx == `CTPP_IDX_WCAP_HI) wcap_hi_q <= wd;
      if (tx_mode) begin
        if (submode == CTPP_SUB_FORCE_LO) begin
          w_out_q <= 1'b0;
        end else if (submode == CTPP_SUB_FORCE_HI) begin
          w_out_q <= 1'b1;
        end else if (!wctl_q[`CTPP_CT_EN] || w_start) begin
          w_out_q <= common_q[`CTPP_CM_INIT_W];
        end else if (w_tc) begin
          w_out_q <= ~w_out_q;
        end
        if (w_start || w_tc) begin
          w_cnt_q <= {wrld_hi_q, wrld_lo_q};
        end else if (w_run) begin
          w_cnt_q <= w_cnt_q - 16'h0001;
        end
      end else begin
        if (w_cap) begin
          wcap_hi_q <= w_cnt_q[15:8];
          wcap_lo_q <= w_cnt_q[7:0];
        end
        if (w_start || w_cap_edge) begin
          w_cnt_q <= {wrld_hi_q, wrld_lo_q};
        end else if (w_wrap) begin
          w_cnt_q <= `CTPP_WRAP;
        end else if (w_run) begin
          w_cnt_q <= w_cnt_q - 16'h0001;
        end
      end
    end
  end

  // Pin and interrupt outputs, registered so they never glitch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port3_bit6_output <= 1'b0;
      narrow_irq <= 1'b0;
      wide_irq <= 1'b0;
      external_interrupt_request_two <= 1'b0;
    end else begin
      // combined output is the OR of both timer outputs
      port3_bit6_output <= (tx_mode & common_q[`CTPP_CM_PINSEL]) ?
                           (n_out_q | w_out_q) : port3_bit6_port_value;
      // terminal count interrupts per timer enable
      narrow_irq <= (n_tc | n_tmo) & nctl_q[`CTPP_CT_TIE];
      wide_irq <= ((w_tc | w_wrap) & wctl_q[`CTPP_CT_TIE]) | (w_cap & wctl_q[`CTPP_CT_CIE]);
      // port3 captures also request external interrupt two
      external_interrupt_request_two <= w_cap & common_q[`CTPP_CM_PINSEL];
    end
  end
  assign narrow_timer_output = n_out_q;
  assign wide_timer_output = w_out_q;

  // Read data is latched in the setup cycle and held through the access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= 32'h0000_0000;
      if (mapped) begin
        unique case (idx)
          `CTPP_IDX_NCTL: prdata_q[7:0] <= nctl_q;
          `CTPP_IDX_COMMON: prdata_q[7:0] <= tx_mode ? common_q :
                                             {common_q[7:2], rise_flag_q, fall_flag_q};
          `CTPP_IDX_WCTL: prdata_q[7:0] <= wctl_q;
          `CTPP_IDX_CTL3: prdata_q[7:0] <= {ctl3_q[7:5], `CTPP_CTL3_RSVD};
          `CTPP_IDX_NRLD_LO: prdata_q[7:0] <= nrld_lo_q;
          `CTPP_IDX_NRLD_HI: prdata_q[7:0] <= nrld_hi_q;
          `CTPP_IDX_WRLD_LO: prdata_q[7:0] <= wrld_lo_q;
          `CTPP_IDX_WRLD_HI: prdata_q[7:0] <= wrld_hi_q;
          `CTPP_IDX_WCAP_LO: prdata_q[7:0] <= wcap_lo_q;
          `CTPP_IDX_WCAP_HI: prdata_q[7:0] <= wcap_hi_q;
          `CTPP_IDX_NCAP_LO: prdata_q[7:0] <= ncap_lo_q;
          default: prdata_q[7:0] <= ncap_hi_q;
        endcase
      end
    end
  end

  // Checks on the block's own behaviour
  filter_four_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($changed(filt_q) && $past(filt_w) == `CTPP_FILT_SHORT) |-> ($past(sel_in, 1) == filt_q &&
    $past(sel_in, 4) == filt_q))
    else $error("filter passed a short pulse");
  narrow_high_cap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!tx_mode && $fell(filt_q) && !wr) |=> ncap_hi_q == $past(n_cnt_q))
    else $error("narrow high capture wrong");
  wide_cap_split_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!tx_mode && w_cap && !wr) |=> {wcap_hi_q, wcap_lo_q} == $past(w_cnt_q))
    else $error("wide capture split wrong");
  wide_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (w_wrap && !w_cap_edge) |=> (w_cnt_q == `CTPP_WRAP && wctl_q[`CTPP_CT_TOF]))
    else $error("wide wrap missing");
  pingpong_hand_a: assert property (@(posedge clk_sys) disable iff (rst)
    (n_tc && pingpong) |=> (!nctl_q[`CTPP_CT_EN] && wctl_q[`CTPP_CT_EN]) ##1
    (w_cnt_q == {wrld_hi_q, wrld_lo_q}))
    else $error("ping-pong handover wrong");
  force_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_mode && submode == CTPP_SUB_FORCE_LO) |=> !wide_timer_output)
    else $error("wide output not forced low");
  ctl3_ones_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_setup && mapped && idx == `CTPP_IDX_CTL3) |=> prdata[4:0] == 5'h1f)
    else $error("control three reserved bits wrong");
  ext_irq_two_a: assert property (@(posedge clk_sys) disable iff (rst)
    (w_cap && common_q[`CTPP_CM_PINSEL]) |=> external_interrupt_request_two)
    else $error("external request two missing");
  rise_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    rise |=> rise_flag_q)
    else $error("rising flag not set");
endmodule
